/* core/chan_ctrl_pkg.sv */
// Constants and types for the per-channel output control register bank
package chan_ctrl_pkg;
  localparam int        FRAME_BITS      = 24;
  localparam int        RW_POS          = 23;
  localparam int        DEV_HI          = 22;
  localparam int        DEV_LO          = 21;
  localparam int        GROUP_HI        = 20;
  localparam int        GROUP_LO        = 18;
  localparam int        CHAN_HI         = 17;
  localparam int        CHAN_LO         = 16;
  localparam int        SUB_HI          = 15;
  localparam int        SUB_LO          = 13;
  localparam logic [2:0] GROUP_CONTROL  = 3'h7;
  localparam logic [2:0] SUB_MAIN       = 3'h1;
  localparam logic [2:0] SUB_CHANNEL    = 3'h2;
  // Main control register fields
  localparam int        GLOB_OUT_POS    = 5;
  localparam int        GLOB_BOOST_POS  = 4;
  // Channel converter control register fields
  localparam int        INT_EN_POS      = 8;
  localparam int        CLR_PART_POS    = 7;
  localparam int        OUT_ON_POS      = 6;
  localparam int        SENSE_POS       = 5;
  localparam int        BOOST_POS       = 4;
  localparam int        RANGE_HI        = 2;
  localparam int        RANGE_LO        = 0;
  localparam logic [2:0] RANGE_4_20     = 3'h4;
  localparam logic [2:0] RANGE_0_20     = 3'h5;
  localparam logic [2:0] RANGE_0_24     = 3'h6;
  localparam logic [2:0] RANGE_RST      = RANGE_4_20;
  localparam logic [4:0] CNT_MAX        = 5'h19;

  typedef struct packed {
    logic       int_en;
    logic       clr_part;
    logic       out_on;
    logic       sense_int;
    logic       boost;
    logic [2:0] range_select;
  } chan_s;

  localparam chan_s CHAN_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, RANGE_RST};

  typedef struct packed {
    logic [3:0] output_on;
    logic [3:0] core_on;
    logic [3:0] boost_on;
    logic [3:0] cleared;
    logic [3:0] sense_internal;
    logic [11:0] range_select;
  } chan_out_s;
endpackage

/* core/channel_output_control_regs.sv */
// Serial-written channel output control register bank, four channels
// Function
// - global output-on enables all four outputs
// - global boost power powers all boosts
// - per-channel register, bits 12:9 and 3 ignored
// - internal enable powers core, not output
// - clear participation routes clear pin per channel
// - channel output-on bit, default disabled
// - sense resistor select, default external
// - range codes 100, 101, 110; others reserved
// - control write when group select is 111
// - write applies only to addressed channel
module channel_output_control_regs
  import chan_ctrl_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst,
  input  wire logic      sclk,
  input  wire logic      sync_n,
  input  wire logic      sdin,
  input  wire logic [1:0] dev_addr,
  input  wire logic      clear_in,
  output chan_out_s      chan_out
);

  typedef struct packed {
    logic [23:0] shift;
    logic [4:0]  cnt;
    logic        sclk_prev;
    logic        sync_prev;
    logic        glob_out;
    logic        glob_boost;
    chan_s [3:0] ch;
    chan_out_s   q;
  } st_s;

  st_s s_r;
  st_s s_nxt;

  logic        frame_done;
  logic        ctrl_hit;
  logic        chan_wr;
  logic        main_wr;
  logic [1:0]  wr_chan;
  logic [15:0] wr_data;

  // Only the three documented range codes are taken
  function automatic logic range_legal(logic [2:0] r);
    return r == RANGE_4_20 || r == RANGE_0_20 || r == RANGE_0_24;
  endfunction

  // Merge one write into a channel; reserved ranges and early
  // boost power-down requests leave the old value in place.
  function automatic chan_s chan_apply(chan_s old, logic [15:0] d);
    chan_s n;
    logic [2:0] rg;
    n           = old;
    rg          = d[RANGE_HI:RANGE_LO];
    n.int_en    = d[INT_EN_POS];
    n.clr_part  = d[CLR_PART_POS];
    n.out_on    = d[OUT_ON_POS];
    n.sense_int = d[SENSE_POS];
    n.boost     = d[BOOST_POS] |
                  (old.boost & (d[OUT_ON_POS] | d[INT_EN_POS]));
    if (range_legal(rg)) begin
      n.range_select = rg;
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Frame decode
  assign frame_done = !s_r.sync_prev && sync_n &&
                      s_r.cnt == 5'(FRAME_BITS);
  assign ctrl_hit   = frame_done && !s_r.shift[RW_POS] &&
                      s_r.shift[DEV_HI:DEV_LO] == dev_addr &&
                      s_r.shift[GROUP_HI:GROUP_LO] == GROUP_CONTROL;
  assign main_wr    = ctrl_hit && s_r.shift[SUB_HI:SUB_LO] == SUB_MAIN;
  assign chan_wr    = ctrl_hit && s_r.shift[SUB_HI:SUB_LO] == SUB_CHANNEL;
  assign wr_chan    = s_r.shift[CHAN_HI:CHAN_LO];
  assign wr_data    = s_r.shift[15:0];

  always_comb begin
    s_nxt           = s_r;
    s_nxt.sclk_prev = sclk;
    s_nxt.sync_prev = sync_n;
    // Bits are taken on the falling serial clock edge
    if (sync_n) begin
      s_nxt.cnt = 5'h00;
    end else if (s_r.sclk_prev && !sclk) begin
      s_nxt.shift = {s_r.shift[22:0], sdin};
      // Saturate so over-long frames are rejected
      if (s_r.cnt != CNT_MAX) begin
        s_nxt.cnt = s_r.cnt + 5'h01;
      end
    end
    if (main_wr) begin
      s_nxt.glob_out   = wr_data[GLOB_OUT_POS];
      s_nxt.glob_boost = wr_data[GLOB_BOOST_POS];
    end
    if (chan_wr) begin
      s_nxt.ch[wr_chan] = chan_apply(s_r.ch[wr_chan], wr_data);
    end
    for (int i = 0; i < 4; i++) begin
      s_nxt.q.output_on[i]      = s_r.ch[i].out_on | s_r.glob_out;
      s_nxt.q.core_on[i]        = s_r.ch[i].int_en;
      s_nxt.q.boost_on[i]       = s_r.ch[i].boost | s_r.ch[i].int_en |
                                  s_r.glob_boost;
      s_nxt.q.cleared[i]        = clear_in & s_r.ch[i].clr_part;
      s_nxt.q.sense_internal[i] = s_r.ch[i].sense_int;
      s_nxt.q.range_select[3*i +: 3] = s_r.ch[i].range_select;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r            <= '0;
      // Idle serial clock is high, so no false edge after reset
      s_r.sclk_prev  <= 1'b1;
      s_r.sync_prev  <= 1'b1;
      s_r.ch         <= {4{CHAN_RST}};
      s_r.q.range_select <= {4{RANGE_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign chan_out = s_r.q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_glob_out;
    @(posedge core_clk) disable iff (rst)
      s_r.glob_out |=> chan_out.output_on == 4'hF;
  endproperty
  a_glob_out: assert property (p_glob_out)
    else $error("global output-on did not enable all outputs");

  property p_glob_boost;
    @(posedge core_clk) disable iff (rst)
      s_r.glob_boost |=> chan_out.boost_on == 4'hF;
  endproperty
  a_glob_boost: assert property (p_glob_boost)
    else $error("global boost did not power all channels");

  property p_int_not_out;
    @(posedge core_clk) disable iff (rst)
      chan_wr && wr_data[INT_EN_POS] && !wr_data[OUT_ON_POS] &&
      !s_r.glob_out
      |=> !s_r.ch[$past(wr_chan)].out_on ##1
          !chan_out.output_on[$past(wr_chan, 2)];
  endproperty
  a_int_not_out: assert property (p_int_not_out)
    else $error("internal enable turned an output on");

  property p_clear;
    @(posedge core_clk) disable iff (rst)
      clear_in && s_r.ch[0].clr_part && !chan_wr
      |=> chan_out.cleared[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("participating channel not cleared");

  property p_out_on;
    @(posedge core_clk) disable iff (rst)
      chan_wr |=> s_r.ch[$past(wr_chan)].out_on ==
                  $past(wr_data[OUT_ON_POS]);
  endproperty
  a_out_on: assert property (p_out_on)
    else $error("channel output-on bit not stored");

  property p_sense;
    @(posedge core_clk) disable iff (rst)
      chan_wr && wr_chan == 2'h1
      |=> ##1 chan_out.sense_internal[1] ==
              $past(wr_data[SENSE_POS], 2);
  endproperty
  a_sense: assert property (p_sense)
    else $error("sense resistor select not applied");

  property p_range_rsvd;
    @(posedge core_clk) disable iff (rst)
      chan_wr && !range_legal(wr_data[RANGE_HI:RANGE_LO])
      |=> s_r.ch[$past(wr_chan)].range_select ==
          $past(s_r.ch[wr_chan].range_select);
  endproperty
  a_range_rsvd: assert property (p_range_rsvd)
    else $error("reserved range code was accepted");

  property p_only_addressed;
    @(posedge core_clk) disable iff (rst)
      chan_wr && wr_chan != 2'h2 |=> $stable(s_r.ch[2]);
  endproperty
  a_only_addressed: assert property (p_only_addressed)
    else $error("write reached a channel not addressed");

  property p_boost_hold;
    @(posedge core_clk) disable iff (rst)
      chan_wr && s_r.ch[wr_chan].boost &&
      (wr_data[OUT_ON_POS] || wr_data[INT_EN_POS])
      |=> s_r.ch[$past(wr_chan)].boost;
  endproperty
  a_boost_hold: assert property (p_boost_hold)
    else $error("boost powered down while channel active");

  property p_core_on;
    @(posedge core_clk) disable iff (rst)
      chan_wr |=> ##1 chan_out.core_on[$past(wr_chan, 2)] ==
                      $past(wr_data[INT_EN_POS], 2);
  endproperty
  a_core_on: assert property (p_core_on)
    else $error("internal enable not applied to its channel");

  property p_range_apply;
    @(posedge core_clk) disable iff (rst)
      chan_wr && range_legal(wr_data[RANGE_HI:RANGE_LO])
      |=> s_r.ch[$past(wr_chan)].range_select ==
          $past(wr_data[RANGE_HI:RANGE_LO]);
  endproperty
  a_range_apply: assert property (p_range_apply)
    else $error("legal range code not stored");

  // Refused frames must leave every register untouched
  property p_foreign_frame;
    @(posedge core_clk) disable iff (rst)
      frame_done && !main_wr && !chan_wr
      |=> $stable(s_r.ch) && $stable(s_r.glob_out) &&
          $stable(s_r.glob_boost);
  endproperty
  a_foreign_frame: assert property (p_foreign_frame)
    else $error("refused frame changed a register");

endmodule // channel_output_control_regs

/* tb/host_model.sv */
// Behavioural host that shifts serial frames into the register bank
module host_model (
  output logic sclk,
  output logic sync_n,
  output logic sdin,
  input  wire logic core_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Short frames (nb below 24) are sent on purpose to be refused
  task automatic send(input logic [23:0] f, input int nb);
    @(negedge core_clk) sync_n = 1'b0;
    for (int i = 23; i > 23 - nb; i--) begin
      repeat (2) @(negedge core_clk);
      sdin = f[i];
      sclk = 1'b1;
      repeat (2) @(negedge core_clk);
      sclk = 1'b0;
    end
    repeat (2) @(negedge core_clk);
    sync_n = 1'b1;
    // Serial clock back to its idle high level between frames
    sclk = 1'b1;
    // Released data line shows the inverse, never a stale bit
    sdin = ~sdin;
    repeat (3) @(negedge core_clk);
  endtask
endmodule // host_model

/* tb/channel_output_control_regs_tb.sv */
// Self-checking bench for the channel output control register bank
`define CHK(nm, e, s) begin num_checks++; if ((e) !== (s)) begin \
  failures++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module channel_output_control_regs_tb
  import chan_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst, sclk, sync_n, sdin, clear_in;
  logic [1:0]  dev_addr;
  logic [23:0] f;
  chan_out_s   chan_out;
  int          failures, num_checks, g_out, g_bst;
  int          m_int[4], m_clr[4], m_out[4], m_sen[4], m_bst[4];
  int          m_rng[4] = '{default: int'(RANGE_RST)};
  host_model hst (.core_clk(core_clk), .sclk(sclk), .sync_n(sync_n),
    .sdin(sdin));
  channel_output_control_regs dut (.core_clk(core_clk), .rst(rst),
    .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .dev_addr(dev_addr),
    .clear_in(clear_in), .chan_out(chan_out));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic chan_out_s exp_out();
    chan_out_s e;
    for (int i = 0; i < 4; i++) begin
      e.output_on[i] = 1'(m_out[i] | g_out);
      e.core_on[i] = 1'(m_int[i]);
      e.boost_on[i] = 1'(m_bst[i] | m_int[i] | g_bst);
      e.cleared[i] = clear_in & 1'(m_clr[i]);
      e.sense_internal[i] = 1'(m_sen[i]);
      e.range_select[3*i +: 3] = 3'(m_rng[i]);
    end
    return e;
  endfunction
  function automatic logic [23:0] mk(logic [1:0] c, logic [2:0] s,
    logic [12:0] d);
    return {1'b0, dev_addr, GROUP_CONTROL, c, s, d};
  endfunction
  task automatic wr(input logic [23:0] w, input int nb);
    int c;
    c = int'(w[CHAN_HI:CHAN_LO]);
    hst.send(w, nb);
    if (nb == 24 && !w[RW_POS] && w[DEV_HI:DEV_LO] == dev_addr &&
        w[GROUP_HI:GROUP_LO] == GROUP_CONTROL) begin
      if (w[SUB_HI:SUB_LO] == SUB_MAIN) begin
        g_out = int'(w[GLOB_OUT_POS]);
        g_bst = int'(w[GLOB_BOOST_POS]);
      end else if (w[SUB_HI:SUB_LO] == SUB_CHANNEL) begin
        m_int[c] = int'(w[INT_EN_POS]);
        m_clr[c] = int'(w[CLR_PART_POS]);
        m_out[c] = int'(w[OUT_ON_POS]);
        m_sen[c] = int'(w[SENSE_POS]);
        if (w[BOOST_POS] || !(w[OUT_ON_POS] || w[INT_EN_POS]))
          m_bst[c] = int'(w[BOOST_POS]);
        if (w[2:0] inside {RANGE_4_20, RANGE_0_20, RANGE_0_24})
          m_rng[c] = int'(w[2:0]);
      end
    end
    `CHK("chan_out", exp_out(), chan_out)
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // Frames plus the settling wait take about a third of this
    #1ms;
    failures++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    dev_addr = 2'h2;
    clear_in = 1'b0;
    void'($urandom(86));
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    `CHK("reset", exp_out(), chan_out)
    // Globals used alone first, outputs off before boost off
    wr(mk(2'h0, SUB_MAIN, 13'h0030), 24);
    wr(mk(2'h0, SUB_MAIN, 13'h0010), 24);
    wr(mk(2'h0, SUB_MAIN, 13'h0000), 24);
    for (int r = 0; r < 8; r++)
      wr(mk(2'(r), SUB_CHANNEL, 13'(r) | 13'h1E08), 24);
    // Core powered first, output only after the settling wait
    wr(mk(2'h1, SUB_CHANNEL, 13'h0104), 24);
    repeat (10050) @(negedge core_clk);
    wr(mk(2'h1, SUB_CHANNEL, 13'h0144), 24);
    for (int k = 0; k < 40; k++) begin
      clear_in = 1'($urandom);
      f = mk(2'($urandom), SUB_CHANNEL, 13'($urandom));
      // Every fourth frame has a random header, mostly refused
      if (k % 4 == 3) begin
        f[23:13] = 11'($urandom);
        // Random main writes keep both global bits clear
        if (f[SUB_HI:SUB_LO] == SUB_MAIN) begin
          f[GLOB_OUT_POS]   = 1'b0;
          f[GLOB_BOOST_POS] = 1'b0;
        end
      end
      wr(f, (k % 7 == 6) ? 23 : 24);
    end
    // Mid-run reset brings every field back to its default
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    g_out = 0;
    g_bst = 0;
    for (int i = 0; i < 4; i++) begin
      m_int[i] = 0;
      m_clr[i] = 0;
      m_out[i] = 0;
      m_sen[i] = 0;
      m_bst[i] = 0;
      m_rng[i] = int'(RANGE_RST);
    end
    @(negedge core_clk);
    `CHK("reset again", exp_out(), chan_out)
    wr(mk(2'h3, SUB_CHANNEL, 13'h0076), 24);
    wrap_up();
  end
endmodule // channel_output_control_regs_tb
